// File: wtu_timer.sv
// Purpose: 16-bit timer/counter with prescaler, crystal pin control and Wishbone registers
// Assumes: clk is the oscillator clock; sleep_i, trig_i, other_rst_i come from clk-domain logic
// Notes:   byte registers sit in bits 7:0 of each word; unmapped reads return zero
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module wtu_timer
  import wtu_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  input  wire logic                 other_rst_i,
  input  wire logic                 sleep_i,
  input  wire logic                 trig_i,
  input  wire logic                 xtal_in_pin,
  input  wire logic                 ext_count_pin,
  input  wire logic [1:0]           port_b_direction,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [WTU_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  output logic                      overflow_irq,
  output logic                      wake_o,
  output logic                      xtal_amp_en,
  output logic                      xtal_in_oe,
  output logic                      xtal_out_oe
);

  typedef struct packed {
    logic [15:0]           count;
    logic [WTU_CTRL_W-1:0] ctrl;
    logic                  flag;
    logic                  ien;
    logic [1:0]            phase;
    logic                  psync;
    logic                  pprev;
    logic                  ack;
    logic [7:0]            rdata;
    logic                  irq;
    logic                  wake;
    logic                  amp;
    logic                  in_oe;
    logic                  out_oe;
  } wtu_state_t;

  wtu_state_t q;
  wtu_state_t d;

  logic [1:0] pins_s;
  logic       ext_src;
  logic       presc_o;
  logic       acc;
  logic       wr;
  logic       rd;
  logic       wr_lo;
  logic       wr_hi;
  logic       cnt_wr;
  logic       int_tick;
  logic       sync_tick;
  logic       async_tick;
  logic       tick;
  logic       inc;
  logic       wrap;

  // the synchronised path looks at the prescaler output only on the two sampling phases of each instruction cycle; the bypass path looks every clock
  function automatic logic wtu_sample_ph(input logic [1:0] ph);
    return (ph == WTU_PH_Q2) || (ph == WTU_PH_Q4);
  endfunction

  wtu_pin_sync u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .pins_i ({xtal_in_pin, ext_count_pin}),
    .pins_o (pins_s)
  );

  // crystal input is counted when the oscillator runs, else the dedicated pin
  assign ext_src = q.ctrl[WTU_B_OSCEN] ? pins_s[1] : pins_s[0];

  wtu_prescaler u_psc (
    .clk    (clk),
    .arst_n (arst_n),
    .src_i  (ext_src),
    .clr_i  (cnt_wr),
    .sel_i  (q.ctrl[WTU_B_PS_HI:WTU_B_PS_LO]),
    .div_o  (presc_o)
  );

  always_comb begin
    d      = q;
    acc    = wb_cyc_i && wb_stb_i && !q.ack;
    wr     = acc && wb_we_i && wb_sel_i[0];
    rd     = acc && !wb_we_i;
    wr_lo  = wr && wtu_hit(wb_adr_i, WTU_IDX_CNT_LO);
    wr_hi  = wr && wtu_hit(wb_adr_i, WTU_IDX_CNT_HI);
    cnt_wr = wr_lo || wr_hi;
    d.ack  = acc;
    d.phase = q.phase + WTU_PH_STEP;

    // instruction clock halts in sleep
    int_tick = (q.phase == WTU_PH_Q4) && !sleep_i;
    // synchroniser samples after the prescaler on Q2/Q4 and is off in sleep
    sync_tick = wtu_sample_ph(q.phase) && !sleep_i && presc_o && !q.psync;
    if (wtu_sample_ph(q.phase) && !sleep_i) begin
      d.psync = presc_o;
    end
    // bypass path keeps counting through sleep
    d.pprev    = presc_o;
    async_tick = presc_o && !q.pprev;
    if (!q.ctrl[WTU_B_CLKSEL]) begin
      tick = int_tick;
    end else if (q.ctrl[WTU_B_SYNCBYP]) begin
      tick = async_tick;
    end else begin
      tick = sync_tick;
    end
    inc  = q.ctrl[WTU_B_RUN] && tick;
    wrap = inc && (q.count == WTU_COUNT_MAX);

    if (other_rst_i) begin
      d.flag = 1'b0;
      d.ien  = 1'b0;
    end
    if (wr && wtu_hit(wb_adr_i, WTU_IDX_CTRL)) begin
      d.ctrl = wb_dat_i[WTU_CTRL_W-1:0];
    end
    if (wr && wtu_hit(wb_adr_i, WTU_IDX_FLAG)) begin
      d.flag = wb_dat_i[WTU_B_FLAG];
    end
    if (wr && wtu_hit(wb_adr_i, WTU_IDX_ENABLE)) begin
      d.ien = wb_dat_i[WTU_B_IEN];
    end

    // a write beats the compare trigger, which beats counting
    if (cnt_wr) begin
      if (wr_lo) begin
        d.count[7:0] = wb_dat_i[7:0];
      end
      if (wr_hi) begin
        d.count[15:8] = wb_dat_i[7:0];
      end
    end else if (trig_i) begin
      d.count = WTU_COUNT_RST;
    end else if (inc) begin
      d.count = q.count + WTU_COUNT_ONE;
    end
    // overflow set wins over a same-cycle clear
    if (wrap && !cnt_wr && !trig_i) begin
      d.flag = 1'b1;
    end

    if (rd) begin
      if (wtu_hit(wb_adr_i, WTU_IDX_CNT_LO)) begin
        d.rdata = q.count[7:0];
      end else if (wtu_hit(wb_adr_i, WTU_IDX_CNT_HI)) begin
        d.rdata = q.count[15:8];
      end else if (wtu_hit(wb_adr_i, WTU_IDX_CTRL)) begin
        d.rdata = {2'h0, q.ctrl};
      end else if (wtu_hit(wb_adr_i, WTU_IDX_FLAG)) begin
        d.rdata = {7'h00, q.flag};
      end else if (wtu_hit(wb_adr_i, WTU_IDX_ENABLE)) begin
        d.rdata = {7'h00, q.ien};
      end else begin
        d.rdata = 8'h00;
      end
    end

    d.irq    = d.flag && d.ien;
    d.wake   = sleep_i && d.flag && d.ien;
    d.amp    = d.ctrl[WTU_B_OSCEN];
    d.in_oe  = !d.ctrl[WTU_B_OSCEN] && !port_b_direction[1];
    d.out_oe = !d.ctrl[WTU_B_OSCEN] && !port_b_direction[0];
  end

  // the count has no defined power-on value; zero is as good as any
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q       <= '0;
      q.ctrl  <= WTU_CTRL_RST;
      q.count <= WTU_COUNT_RST;
    end else begin
      q <= d;
    end
  end

  assign wb_dat_o     = {24'h000000, q.rdata};
  assign wb_ack_o     = q.ack;
  assign overflow_irq = q.irq;
  assign wake_o       = q.wake;
  assign xtal_amp_en  = q.amp;
  assign xtal_in_oe   = q.in_oe;
  assign xtal_out_oe  = q.out_oe;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_wrap;
    inc && (q.count == WTU_COUNT_MAX) && !cnt_wr && !trig_i;
  endsequence

  sequence s_no_touch;
    !cnt_wr && !trig_i;
  endsequence

  sequence s_tick_gap;
    (!int_tick)[*3] ##1 (int_tick || sleep_i);
  endsequence

  property p_wrap_zero;
    s_wrap |=> (q.count == WTU_COUNT_RST) && q.flag;
  endproperty
  a_wrap_zero: assert property (p_wrap_zero) else $error("wrap did not clear count or set flag");

  property p_irq_gate;
    (s_wrap and (q.ien && !other_rst_i && !wr)) |=> overflow_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt not raised");

  property p_irq_mask;
    !q.ien |-> !overflow_irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt raised");

  property p_int_period;
    int_tick |=> s_tick_gap;
  endproperty
  a_int_period: assert property (p_int_period) else $error("instruction tick spacing wrong");

  property p_halt;
    ((!q.ctrl[WTU_B_RUN]) and s_no_touch) |=> $stable(q.count);
  endproperty
  a_halt: assert property (p_halt) else $error("count moved while halted");

  property p_sleep_sync;
    ((sleep_i && q.ctrl[WTU_B_CLKSEL] && !q.ctrl[WTU_B_SYNCBYP]) and s_no_touch) |=> $stable(q.count);
  endproperty
  a_sleep_sync: assert property (p_sleep_sync) else $error("synchronised count moved in sleep");

  property p_trig_clear;
    (trig_i && !cnt_wr && !wr && !other_rst_i) |=> (q.count == WTU_COUNT_RST) && (q.flag == $past(q.flag));
  endproperty
  a_trig_clear: assert property (p_trig_clear) else $error("trigger clear wrong");

  property p_write_wins;
    (trig_i && wr_lo && !wr_hi) |=> q.count[7:0] == $past(wb_dat_i[7:0]);
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("write lost to trigger");

  property p_ctrl_read;
    (rd && wtu_hit(wb_adr_i, WTU_IDX_CTRL)) |=> wb_ack_o && (wb_dat_o[7:6] == 2'h0);
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("unimplemented control bits nonzero");

  property p_flag_hold;
    (q.flag && !other_rst_i && !(wr && wtu_hit(wb_adr_i, WTU_IDX_FLAG))) |=> q.flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without clear");

  property p_pins_input;
    q.ctrl[WTU_B_OSCEN] |-> !xtal_in_oe && !xtal_out_oe && xtal_amp_en;
  endproperty
  a_pins_input: assert property (p_pins_input) else $error("crystal pins driven");

  property p_timer_tick;
    ((!q.ctrl[WTU_B_CLKSEL] && q.ctrl[WTU_B_RUN] && int_tick) and s_no_touch)
      |=> q.count == $past(q.count) + WTU_COUNT_ONE;
  endproperty
  a_timer_tick: assert property (p_timer_tick) else $error("timer tick did not advance count");

  property p_ext_idle;
    ((q.ctrl[WTU_B_CLKSEL] && !presc_o) and s_no_touch) |=> $stable(q.count);
  endproperty
  a_ext_idle: assert property (p_ext_idle) else $error("count moved without a prescaler edge");

  property p_ack_answer;
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("bus request not acknowledged");

  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("acknowledge held too long");

  property p_lo_write;
    (wr_lo && !wr_hi) |=> q.count[7:0] == $past(wb_dat_i[7:0]);
  endproperty
  a_lo_write: assert property (p_lo_write) else $error("low count byte write lost");

  property p_hi_write;
    wr_hi |=> q.count[15:8] == $past(wb_dat_i[7:0]);
  endproperty
  a_hi_write: assert property (p_hi_write) else $error("high count byte write lost");

  // the first sample after reset release still shows reset outputs, hence the guard
  property p_osc_off;
    (!q.ctrl[WTU_B_OSCEN] && $past(arst_n)) |-> !xtal_amp_en
      && (xtal_in_oe == !$past(port_b_direction[1])) && (xtal_out_oe == !$past(port_b_direction[0]));
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("pin drive wrong with oscillator off");

  property p_bypass_sleep;
    ((sleep_i && q.ctrl[WTU_B_RUN] && q.ctrl[WTU_B_CLKSEL] && q.ctrl[WTU_B_SYNCBYP] && presc_o && !q.pprev)
      and s_no_touch) |=> q.count == $past(q.count) + WTU_COUNT_ONE;
  endproperty
  a_bypass_sleep: assert property (p_bypass_sleep) else $error("unsynchronised count stopped in sleep");

  property p_wake;
    (wrap && sleep_i && q.ien && !other_rst_i && !wr && !trig_i) |=> wake_o;
  endproperty
  a_wake: assert property (p_wake) else $error("overflow in sleep did not wake");

  property p_other_rst;
    (other_rst_i && !wrap && !wr) |=> !q.flag && !q.ien && $stable(q.ctrl);
  endproperty
  a_other_rst: assert property (p_other_rst) else $error("other reset handled wrongly");

  property p_ctrl_write;
    (wr && wtu_hit(wb_adr_i, WTU_IDX_CTRL)) |=> q.ctrl == $past(wb_dat_i[WTU_CTRL_W-1:0]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

  property p_sel_ignore;
    (acc && wb_we_i && !wb_sel_i[0] && wtu_hit(wb_adr_i, WTU_IDX_CTRL)) |=> $stable(q.ctrl);
  endproperty
  a_sel_ignore: assert property (p_sel_ignore) else $error("unselected byte changed control");

endmodule // wtu_timer
`default_nettype wire

// File: wtu_pkg.sv
// Purpose: shared constants for the wide timer unit
// Assumes: 8-bit registers on a 32-bit classic Wishbone bus, one aligned word each
// Notes:   register indices are word indices; byte address is index times four
package wtu_pkg;

  // register word indices (byte address = index * 4)
  localparam logic [7:0] WTU_IDX_FLAG    = 8'h0C;
  localparam logic [7:0] WTU_IDX_CNT_LO  = 8'h0E;
  localparam logic [7:0] WTU_IDX_CNT_HI  = 8'h0F;
  localparam logic [7:0] WTU_IDX_CTRL    = 8'h10;
  localparam logic [7:0] WTU_IDX_ENABLE  = 8'h8C;

  localparam int WTU_ADR_W   = 10;
  localparam int WTU_IDX_LSB = 2;

  // control, flag and enable field positions
  localparam int WTU_B_RUN     = 0;
  localparam int WTU_B_CLKSEL  = 1;
  localparam int WTU_B_SYNCBYP = 2;
  localparam int WTU_B_OSCEN   = 3;
  localparam int WTU_B_PS_LO   = 4;
  localparam int WTU_B_PS_HI   = 5;
  localparam int WTU_CTRL_W    = 6;
  localparam int WTU_B_FLAG    = 0;
  localparam int WTU_B_IEN     = 0;

  localparam logic [WTU_CTRL_W-1:0] WTU_CTRL_RST  = 6'h00;
  localparam logic [15:0]           WTU_COUNT_RST = 16'h0000;
  localparam logic [15:0]           WTU_COUNT_MAX = 16'hFFFF;
  localparam logic [15:0]           WTU_COUNT_ONE = 16'h0001;

  // four oscillator clocks per instruction cycle; sampling on the second and fourth
  localparam logic [1:0] WTU_PH_STEP = 2'h1;
  localparam logic [1:0] WTU_PH_Q2   = 2'h1;
  localparam logic [1:0] WTU_PH_Q4   = 2'h3;

  function automatic logic wtu_hit(input logic [WTU_ADR_W-1:0] adr, input logic [7:0] idx);
    return adr[WTU_ADR_W-1:WTU_IDX_LSB] == idx;
  endfunction

endpackage

// File: wtu_pin_sync.sv
// Purpose: two-flop synchroniser for the two counting pins
// Assumes: pins are asynchronous to clk
// Notes:   first stage is read only by the second
`timescale 1ns/1ns
`default_nettype none
module wtu_pin_sync
  import wtu_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [1:0] pins_i,
  output logic      [1:0] pins_o
);

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
  } wtu_sync_t;

  wtu_sync_t q;
  wtu_sync_t d;

  always_comb begin
    d    = q;
    d.s1 = pins_i;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pins_o = q.s2;

endmodule // wtu_pin_sync
`default_nettype wire

// File: wtu_prescaler.sv
// Purpose: divide-by-1/2/4/8 prescaler on the external count input
// Assumes: src_i is already synchronised to clk
// Notes:   modelled as a counter advancing on source rising edges, which matches the
//          outputs of a ripple chain; it runs regardless of sleep
`timescale 1ns/1ns
`default_nettype none
module wtu_prescaler
  import wtu_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       src_i,
  input  wire logic       clr_i,
  input  wire logic [1:0] sel_i,
  output logic            div_o
);

  typedef struct packed {
    logic       prev;
    logic [2:0] stage;
    logic       out;
  } wtu_psc_t;

  wtu_psc_t q;
  wtu_psc_t d;

  always_comb begin
    d      = q;
    d.prev = src_i;
    if (clr_i) begin
      d.stage = '0;
    end else if (src_i && !q.prev) begin
      d.stage = q.stage + 3'h1;
    end
    d.out = (sel_i == 2'h0) ? src_i : q.stage[sel_i - 2'h1];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign div_o = q.out;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_clr_zero;
    clr_i |=> q.stage == 3'h0;
  endproperty
  a_clr_zero: assert property (p_clr_zero) else $error("prescaler not cleared");

  property p_div8_out;
    (sel_i == 2'h3) |=> (q.out == $past(q.stage[2]));
  endproperty
  a_div8_out: assert property (p_div8_out) else $error("divide by 8 output wrong");

endmodule // wtu_prescaler
`default_nettype wire

// File: wtu_clk_src.sv
// Purpose: external count source facing the wide timer unit pins
// Assumes: bursts are launched from the bench clock domain
// Notes:   both pins rest low between bursts, like an idle source
`timescale 1ns/1ns
`default_nettype none
module wtu_clk_src (
  input  wire logic clk,
  output var logic  xtal_in_pin,
  output var logic  ext_count_pin
);
  initial begin
    xtal_in_pin   = 1'b0;
    ext_count_pin = 1'b0;
  end
  // pin 1 drives the crystal input, 0 the dedicated pin; half sets the speed
  task automatic burst(input logic pin, input int n, input int half);
    for (int i = 0; i < n; i++) begin
      if (pin) xtal_in_pin <= 1'b1;
      else ext_count_pin <= 1'b1;
      repeat (half) @(posedge clk);
      if (pin) xtal_in_pin <= 1'b0;
      else ext_count_pin <= 1'b0;
      repeat (half) @(posedge clk);
    end
  endtask
endmodule // wtu_clk_src
`default_nettype wire

// File: wtu_timer_test.sv
// Purpose: self-checking bench for the wide timer unit
// Assumes: registers one per word, byte address = index times four
// Notes:   pulse counts are random, expected counts follow from the prescale
`timescale 1ns/1ns
`default_nettype none
module wtu_timer_test;
  import wtu_pkg::*;
  localparam logic [9:0] A_FLAG = 10'h030;
  localparam logic [9:0] A_LO   = 10'h038;
  localparam logic [9:0] A_HI   = 10'h03C;
  localparam logic [9:0] A_CTRL = 10'h040;
  localparam logic [9:0] A_EN   = 10'h230;
  localparam logic [9:0] A_BAD  = 10'h104;
  logic        clk = 1'b0, arst_n = 1'b0, orst = 1'b0, sleep = 1'b0, trig = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0]  sel = 4'hF;
  logic [9:0]  adr = 10'h000;
  logic [31:0] dat = 32'h0, rq;
  logic [1:0]  dir = 2'h0;
  logic [15:0] cnt, keep;
  wire logic [31:0] rdat;
  wire logic   ack, irq, wake, amp, in_oe, out_oe, xin, xcnt;
  int          failures = 0, check_count = 0, seed = 32'hA360, n, p;

  always #10 clk = ~clk;

  wtu_timer i_wtu_timer (.clk(clk), .arst_n(arst_n), .other_rst_i(orst), .sleep_i(sleep),
    .trig_i(trig), .xtal_in_pin(xin), .ext_count_pin(xcnt), .port_b_direction(dir),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .overflow_irq(irq), .wake_o(wake),
    .xtal_amp_en(amp), .xtal_in_oe(in_oe), .xtal_out_oe(out_oe));
  wtu_clk_src i_wtu_clk_src (.clk(clk), .xtal_in_pin(xin), .ext_count_pin(xcnt));

  task automatic check(input logic [31:0] got, input logic [31:0] want);
    check_count++;
    if (got !== want) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  // one classic cycle; called just after a rising edge, leaves one idle cycle
  task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= {24'h0, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rq = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [9:0] a, input logic [31:0] e);
    wb(1'b0, a, 8'h00);
    check(rq, e);
  endtask
  task automatic setcnt(input logic [15:0] v);
    wb(1'b1, A_LO, v[7:0]);
    wb(1'b1, A_HI, v[15:8]);
  endtask
  task automatic getcnt();
    wb(1'b0, A_LO, 8'h00);
    cnt[7:0] = rq[7:0];
    wb(1'b0, A_HI, 8'h00);
    cnt[15:8] = rq[7:0];
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    failures++;
    test_done();
  end

  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    check({amp, in_oe, out_oe, irq}, 4'h6);
    rdchk(A_CTRL, 32'h0);
    rdchk(A_FLAG, 32'h0);
    wb(1'b1, A_BAD, 8'hFF);
    rdchk(A_BAD, 32'h0);
    wb(1'b1, A_CTRL, 8'hFF);
    rdchk(A_CTRL, 32'h3F);
    check({amp, in_oe, out_oe}, 3'h4);
    wb(1'b1, A_CTRL, 8'h00);
    dir <= 2'h1;
    repeat (2) @(posedge clk);
    check({amp, in_oe, out_oe}, 3'h2);
    // every prescale code with each pin choice and sync setting
    for (int m = 0; m < 16; m++) begin
      p = m % 4;
      n = 1 + ($unsigned($random(seed)) % 20);
      wb(1'b1, A_CTRL, {2'h0, p[1:0], m[2], m[3], 2'h3});
      setcnt(16'h0000);
      i_wtu_clk_src.burst(m[2], n, 4);
      i_wtu_clk_src.burst(~m[2], 3, 4);
      repeat (8) @(posedge clk);
      getcnt();
      // a ripple stage goes high halfway through each group of input edges, so halves round up
      check(cnt, (n + ((1 << p) >> 1)) >> p);
    end
    wb(1'b1, A_CTRL, 8'h03);
    setcnt(16'hFFFF);
    wb(1'b1, A_EN, 8'h01);
    i_wtu_clk_src.burst(1'b0, 1, 4);
    repeat (8) @(posedge clk);
    check(irq, 1'b1);
    rdchk(A_FLAG, 32'h1);
    getcnt();
    check(cnt, 16'h0000);
    wb(1'b1, A_EN, 8'h00);
    check(irq, 1'b0);
    rdchk(A_FLAG, 32'h1);
    wb(1'b1, A_FLAG, 8'h00);
    rdchk(A_FLAG, 32'h0);
    sleep <= 1'b1;
    wb(1'b1, A_EN, 8'h01);
    setcnt(16'hFFFF);
    i_wtu_clk_src.burst(1'b0, 2, 4);
    repeat (8) @(posedge clk);
    getcnt();
    check(cnt, 16'hFFFF);
    wb(1'b1, A_CTRL, 8'h07);
    setcnt(16'hFFFF);
    i_wtu_clk_src.burst(1'b0, 1, 4);
    repeat (8) @(posedge clk);
    check(wake, 1'b1);
    sleep <= 1'b0;
    getcnt();
    check(cnt, 16'h0000);
    check(wake, 1'b0);
    wb(1'b1, A_FLAG, 8'h00);
    setcnt(16'h0000);
    wb(1'b1, A_CTRL, 8'h01);
    repeat (40) @(posedge clk);
    wb(1'b1, A_CTRL, 8'h00);
    getcnt();
    check(cnt >= 16'h000A && cnt <= 16'h000B, 1'b1);
    keep = cnt;
    repeat (20) @(posedge clk);
    getcnt();
    check(cnt, keep);
    setcnt(16'h1234);
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
    getcnt();
    check(cnt, 16'h0000);
    rdchk(A_FLAG, 32'h0);
    fork
      wb(1'b1, A_LO, 8'h55);
      begin
        trig <= 1'b1;
        @(posedge clk);
        trig <= 1'b0;
      end
    join
    rdchk(A_LO, 32'h55);
    wb(1'b1, A_FLAG, 8'h01);
    wb(1'b1, A_CTRL, 8'h30);
    sel <= 4'hE;
    wb(1'b1, A_CTRL, 8'h0F);
    sel <= 4'hF;
    rdchk(A_CTRL, 32'h30);
    getcnt();
    keep = cnt;
    orst <= 1'b1;
    @(posedge clk);
    orst <= 1'b0;
    @(posedge clk);
    rdchk(A_FLAG, 32'h0);
    rdchk(A_EN, 32'h0);
    rdchk(A_CTRL, 32'h30);
    getcnt();
    check(cnt, keep);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rdchk(A_CTRL, 32'h0);
    test_done();
  end
endmodule // wtu_timer_test
`default_nettype wire
